// ===== verilog/svtx_defines.vh
`ifndef SVTX_DEFINES_VH
`define SVTX_DEFINES_VH
`define SVTX_ADDR_TRANSMIT    7'h66
`define SVTX_ADDR_STATUS      7'h6e
`define SVTX_CODE_RESET       8'hff
`define SVTX_BUSY_BIT         8
`define SVTX_BLOCKED_BIT      9
`define SVTX_ACKERR_BIT       10
`define SVTX_BIT_TIME_NS      1000
`define SVTX_CLK_PERIOD_NS    10
`define SVTX_BIT_CYCLES       (`SVTX_BIT_TIME_NS / `SVTX_CLK_PERIOD_NS)
`define SVTX_FRAME_BITS       4'h9
`define SVTX_ACK_WAIT         8'h64
`endif

// ===== verilog/svtx_bit_timer.v
`timescale 1ns/1ps
`include "svtx_defines.vh"
module svtx_bit_timer (
  input  wire ref_clk_in,
  input  wire rst_n_in,
  input  wire run_in,
  output reg  tick_out
);
  reg [7:0] count;
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      count    <= 8'h00;
      tick_out <= 1'b0;
    end else if (count == (`SVTX_BIT_CYCLES - 1)) begin
      count    <= 8'h00;
      tick_out <= 1'b1;
    end else begin
      count    <= count + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule

// ===== verilog/svtx_supply_tx.v
//
// Behaviour
// - After reset the voltage code register holds all ones.
// - Writes to the voltage code are ignored until the pending transmission ends.
// - An unacknowledged transfer is retried once, and a failed retry sets the acknowledge error at bit 10.
// - A write discarded because busy is set raises the blocked-write error at bit 9.
// - Both error flags clear only while the err_clear_in input is high; writes to the status register do not clear them.
// - Busy at bit 8 is high while a code is being sent or waits to be sent.
// - Busy clears only once the pending code is acknowledged or its retry has failed, not when the last bit is sent.
// - The last-code field takes only successfully sent codes and resets to all ones.
// - The status register is read-only and bits 15 to 11 read as zero.
//
`timescale 1ns/1ps
`include "svtx_defines.vh"
module svtx_supply_tx (
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  input  wire        reg_wr_in,
  input  wire        reg_rd_in,
  input  wire [6:0]  reg_addr_in,
  input  wire [15:0] reg_wdata_in,
  input  wire        err_clear_in,
  input  wire        link_ack_in,
  output reg  [15:0] reg_rdata_out,
  output reg         link_data_out,
  output reg         link_active_out,
  output reg         supply_error_out
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  localparam ST_IDLE = 4'b0001;
  localparam ST_SEND = 4'b0010;
  localparam ST_ACK  = 4'b0100;
  localparam ST_DONE = 4'b1000;
  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function addr_hit;
    input [6:0] addr;
    input [6:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction
  reg  [3:0] state;
  reg  [7:0] code;
  reg  [7:0] last_code;
  reg        busy;
  reg        ack_err;
  reg        blk_err;
  reg        retried;
  reg        acked;
  reg  [3:0] bit_idx;
  reg  [8:0] shift;
  reg  [7:0] wait_cnt;
  wire       tick;
  wire       wr_tx = reg_wr_in && addr_hit(reg_addr_in, `SVTX_ADDR_TRANSMIT);
  wire       rd_tx = reg_rd_in && addr_hit(reg_addr_in, `SVTX_ADDR_TRANSMIT);
  wire       rd_st = reg_rd_in && addr_hit(reg_addr_in, `SVTX_ADDR_STATUS);
  reg [15:0] status_word;
  reg [15:0] next_rdata;
  svtx_bit_timer u_timer (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .run_in     (state == ST_SEND),
    .tick_out   (tick)
  );
  // ----------------------------------------
  // Register writes and flags
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      code    <= `SVTX_CODE_RESET;
      blk_err <= 1'b0;
    end else begin
      if (wr_tx && !busy) begin
        code <= reg_wdata_in[7:0];
      end
      if (wr_tx && busy) begin
        blk_err <= 1'b1;
      end else if (err_clear_in) begin
        blk_err <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Transmit sequencer
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state           <= ST_IDLE;
      busy            <= 1'b0;
      ack_err         <= 1'b0;
      retried         <= 1'b0;
      acked           <= 1'b0;
      bit_idx         <= 4'h0;
      shift           <= 9'h000;
      wait_cnt        <= 8'h00;
      last_code       <= `SVTX_CODE_RESET;
      link_data_out   <= 1'b1;
      link_active_out <= 1'b0;
    end else begin
      if (err_clear_in && !(state == ST_DONE && !acked && retried)) begin
        ack_err <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (wr_tx && !busy) begin
            busy            <= 1'b1;
            retried         <= 1'b0;
            state           <= ST_SEND;
            shift           <= {reg_wdata_in[7:0], 1'b0};
            bit_idx         <= 4'h0;
            link_active_out <= 1'b1;
          end
        end
        ST_SEND: begin
          link_data_out <= shift[0];
          if (tick) begin
            shift <= {1'b1, shift[8:1]};
            if (bit_idx == `SVTX_FRAME_BITS) begin
              state         <= ST_ACK;
              wait_cnt      <= 8'h00;
              acked         <= 1'b0;
              link_data_out <= 1'b1;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        ST_ACK: begin
          wait_cnt <= wait_cnt + 8'h01;
          if (link_ack_in) begin
            acked <= 1'b1;
            state <= ST_DONE;
          end else if (wait_cnt == `SVTX_ACK_WAIT) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (acked) begin
            last_code       <= code;
            busy            <= 1'b0;
            link_active_out <= 1'b0;
            state           <= ST_IDLE;
          end else if (!retried) begin
            retried <= 1'b1;
            shift   <= {code, 1'b0};
            bit_idx <= 4'h0;
            state   <= ST_SEND;
          end else begin
            ack_err         <= 1'b1;
            busy            <= 1'b0;
            link_active_out <= 1'b0;
            state           <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------
  // Status word
  // ----------------------------------------
  always @* begin
    status_word                    = 16'h0000;
    status_word[7:0]               = last_code;
    status_word[`SVTX_BUSY_BIT]    = busy;
    status_word[`SVTX_BLOCKED_BIT] = blk_err;
    status_word[`SVTX_ACKERR_BIT]  = ack_err;
  end
  // ----------------------------------------
  // Read data select
  // ----------------------------------------
  always @* begin
    next_rdata = reg_rdata_out;
    if (rd_tx) begin
      next_rdata = {8'h00, code};
    end else if (rd_st) begin
      next_rdata = status_word;
    end else if (reg_rd_in) begin
      next_rdata = 16'h0000;
    end
  end
  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out    <= 16'h0000;
      supply_error_out <= 1'b0;
    end else begin
      supply_error_out <= ack_err | blk_err;
      reg_rdata_out    <= next_rdata;
    end
  end
endmodule

// ===== sim/svtx_partner.sv
`timescale 1ns/1ps
module svtx_partner (
  input  wire       ref_clk_in,
  input  wire       link_data_out,
  input  wire       ack_en_in,
  input  wire [5:0] dly_in,
  output reg        link_ack_out = 0
);
  int c = 0;
  always @(posedge ref_clk_in) begin
    c <= c ? (c + 1) % 1100 : !link_data_out;
    link_ack_out <= ack_en_in && c > 1001 + dly_in && c < 1011 + dly_in;
  end
endmodule

// ===== sim/svtx_supply_tx_properties.sv
`timescale 1ns/1ps
module svtx_chk (
  input wire        ref_clk_in,
  input wire        rst_n_in,
  input wire        reg_wr_in,
  input wire        reg_rd_in,
  input wire [6:0]  reg_addr_in,
  input wire        err_clear_in,
  input wire [15:0] reg_rdata_out,
  input wire        link_data_out,
  input wire        link_active_out,
  input wire        supply_error_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_wtx; reg_wr_in && reg_addr_in == 7'h66; endsequence
  sequence s_rst; reg_rd_in && reg_addr_in == 7'h6e; endsequence
  property p_acc; s_wtx ##0 !link_active_out |=> link_active_out; endproperty
  property p_ref; s_wtx ##0 link_active_out |-> ##2 supply_error_out; endproperty
  property p_clr; $fell(supply_error_out) |-> $past(err_clear_in, 2); endproperty
  property p_idle; !link_active_out |-> link_data_out; endproperty
  property p_rsv; s_rst |=> reg_rdata_out[15:11] == 5'h00; endproperty
  property p_unm; reg_rd_in && reg_addr_in != 7'h66 && reg_addr_in != 7'h6e |=> reg_rdata_out == 16'h0000; endproperty
  property p_bsy; s_rst ##0 link_active_out && $past(link_active_out) |=> reg_rdata_out[8]; endproperty
  property p_why; $rose(supply_error_out) |-> $past(link_active_out, 2); endproperty
  a_acc: assert property (p_acc) else $error("accept");
  a_ref: assert property (p_ref) else $error("refuse");
  a_clr: assert property (p_clr) else $error("clear");
  a_idle: assert property (p_idle) else $error("idle");
  a_rsv: assert property (p_rsv) else $error("reserved");
  a_unm: assert property (p_unm) else $error("unmapped");
  a_bsy: assert property (p_bsy) else $error("busy");
  a_why: assert property (p_why) else $error("cause");
endmodule
bind svtx_supply_tx svtx_chk i_svtx_chk (.*);

// ===== sim/svtx_supply_tx_tb_top.sv
`timescale 1ns/1ps
module svtx_supply_tx_tb_top;
  reg         clk = 0, rst_n = 1, wr = 0, rd = 0, clr = 0, ack_en = 1;
  reg  [6:0]  addr = 0;
  reg  [15:0] wd = 0;
  reg  [5:0]  dly = 0;
  reg  [7:0]  lf = 8'h55;
  wire [15:0] rdata;
  wire        data, act, err, ack;
  int mismatches = 0, comparisons = 0, cyc = 0, m_code = 255, m_last = 255, m_blk = 0, m_ack = 0;
  svtx_supply_tx i_svtx_supply_tx (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wd), .err_clear_in(clr), .link_ack_in(ack), .reg_rdata_out(rdata),
    .link_data_out(data), .link_active_out(act), .supply_error_out(err));
  svtx_partner i_svtx_partner (.ref_clk_in(clk), .link_data_out(data), .ack_en_in(ack_en), .dly_in(dly),
    .link_ack_out(ack));
  initial forever #5 clk = ~clk;
  function automatic [7:0] lfsr(input [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic int st(input int b);
    st = (m_ack << 10) | (m_blk << 9) | (b << 8) | m_last;
  endfunction
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task acc(input r, input [6:0] a, input [15:0] d);
    @(posedge clk);
    rd <= r;
    wr <= !r;
    addr <= a;
    wd <= d;
    @(posedge clk);
    rd <= 0;
    wr <= 0;
    @(posedge clk);
  endtask
  task rdc(input [6:0] a, input int e);
    acc(1, a, 0);
    comparisons++;
    if (rdata !== e[15:0]) begin
      mismatches++;
      $display("BAD %0t addr %h got %h", $time, a, rdata);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    rst_n <= 0;
    repeat (5) @(posedge clk);
    rst_n <= 1;
    rdc(7'h66, 255);
    rdc(7'h6e, st(0));
    rdc(7'h70, 0);
    for (int k = 0; k < 2; k++) begin
      lf = lfsr(lf);
      ack_en <= !k;
      dly <= lf[5:0];
      acc(0, 7'h66, {8'hff, lf});
      m_code = lf;
      acc(0, 7'h66, 16'h0000);
      m_blk = 1;
      rdc(7'h6e, st(1));
      rdc(7'h66, m_code);
      for (int i = 0; i < 2500 && act; i++) @(posedge clk);
      if (k == 0) m_last = m_code;
      else m_ack = 1;
      rdc(7'h6e, st(0));
      acc(0, 7'h6e, 16'hffff);
      rdc(7'h6e, st(0));
      @(posedge clk) clr <= 1;
      @(posedge clk) clr <= 0;
      m_blk = 0;
      m_ack = 0;
      rdc(7'h6e, st(0));
    end
    results();
  end
endmodule
